// file: src/rmrx_ctrl.sv
// What this block does
// - Code 00 and powered up: manual detect, inputs high impedance.
// - Code 01: probe every 12 ms, stop after 600 ms, 50 ohm once found.
// - Code 10 (default): probe every 12 ms without limit, 50 ohm once found.
// - Code 11: manual detect, inputs held at 50 ohm.
// - Power-down input high: inputs high impedance, output drivers off.
// - Power-down pulse of at least 5 us then low restarts detection.
// - Slave mode: override bit plus toggled value bit restarts detection.
// - Threshold pin levels 0,R,F,1 give codes 10,01,00,11 in both fields.
// - Mode pin low pin mode, high slave mode, float master loading.
// - Pin mode: settings per side, swing follows de-emphasis level.
// - SMBus modes: swing, equalizer, de-emphasis, termination per lane.
// - SMBus modes: registers take over at once, pins become address.
// - Rate, detect, threshold pins rule until register override set.
// - Registers return to defaults at reset and while mode pin is low.
// - Power-down in slave mode leaves registers untouched.
// - Registers give 256 equalizer settings, pins a 16 entry subset.
// - Address inputs default 0000, address byte B0.
// - Seven-bit address is 58 hex plus address input value.
// - Address byte LSB is direction, zero meaning write.
// - Floating rate pin applies de-emphasis at all three generations.
// - Write: address, index, data, each acknowledged low, then stop.
// - Read: index write, repeated start, address read, one byte, NACK.
`timescale 1ns/1ps
`default_nettype none
module rmrx_ctrl #(
	parameter int unsigned PROBE_CYC = rmrx_pkg::PROBE_CYC,  // Probe interval cycles
	parameter int unsigned LIMIT_CYC = rmrx_pkg::LIMIT_CYC   // Probe limit cycles
) (
	input wire logic i_sys_clk,                               // 40 MHz clock
	input wire logic i_rstn,                                  // Async reset
	input wire logic [1:0] i_config_source_select,            // Mode pin level
	input wire logic i_present_powerdown,                     // Power-down pin
	input wire logic [1:0] i_receiver_detect_select,          // Detect pin level
	input wire logic [1:0] i_idle_threshold_select,           // Threshold pin level
	input wire logic [1:0] i_rate_select,                     // Rate pin level
	input wire logic [3:0] i_equalizer_level_pins_a,          // Side A equalizer pins
	input wire logic [3:0] i_equalizer_level_pins_b,          // Side B equalizer pins
	input wire logic [3:0] i_side_swing_deemphasis_pins_a,    // Side A swing pins
	input wire logic [3:0] i_side_swing_deemphasis_pins_b,    // Side B swing pins
	input wire logic [7:0] i_rx_found,                        // Probe result per lane
	input wire logic i_scl,                                   // SMBus clock
	input wire logic i_sda,                                   // SMBus data in
	output logic o_sda_o,                                     // SMBus data out
	output logic o_sda_oe,                                    // SMBus data enable
	output logic [7:0] o_term_50,                             // 50 ohm per lane
	output logic o_drv_en,                                    // Output drivers on
	output logic o_probe,                                     // Probe strobe
	output logic [63:0] o_eq_code,                            // Equalizer per lane
	output logic [63:0] o_output_swing_deemphasis_level,      // Swing per lane
	output logic [3:0] o_idle_thr,                            // Threshold fields
	output logic [1:0] o_rate,                                // Rate selection
	output logic o_deemph_all_gen,                            // All generations
	output logic o_slave_mode,                                // Slave mode
	output logic o_master_mode                                // Master loading
);
	// ----------------------------------------
	// Mode and pin decode
	// ----------------------------------------
	rmrx_pkg::rmrx_st_t q;
	rmrx_pkg::rmrx_st_t d;
	logic pinm;
	logic smb;
	logic slave;
	logic [3:0] ad;
	logic [6:0] addr;
	logic start;
	logic stop;
	logic rise;
	logic fall;
	logic [7:0] rdata;
	logic pd;
	logic sw_ovr;
	logic [1:0] code;
	logic code_auto;
	logic [7:0] tdis;
	logic [rmrx_pkg::NCH-1:0][7:0] eq_nx;
	logic [rmrx_pkg::NCH-1:0][7:0] sw_nx;

	assign pinm = i_config_source_select == rmrx_pkg::LVL_LO;
	assign slave = i_config_source_select == rmrx_pkg::LVL_HI;
	assign smb = !pinm;
	assign ad = {i_side_swing_deemphasis_pins_b[1:0] == rmrx_pkg::LVL_HI,
		i_side_swing_deemphasis_pins_a[1:0] == rmrx_pkg::LVL_HI,
		i_equalizer_level_pins_b[1:0] == rmrx_pkg::LVL_HI,
		i_equalizer_level_pins_a[1:0] == rmrx_pkg::LVL_HI};
	assign addr = rmrx_pkg::SLV_BASE + {3'h0, ad};
	assign start = q.scl_p && i_scl && q.sda_p && !i_sda;
	assign stop = q.scl_p && i_scl && !q.sda_p && i_sda;
	assign rise = !q.scl_p && i_scl;
	assign fall = q.scl_p && !i_scl;
	assign rdata = (q.idx < rmrx_pkg::REG_NUM) ? q.regs[q.idx[4:0]] : 8'h00;
	assign sw_ovr = slave && q.regs[rmrx_pkg::REG_DET][rmrx_pkg::PD_OVR_BIT];
	assign pd = sw_ovr ? q.regs[rmrx_pkg::REG_DET][rmrx_pkg::PD_VAL_BIT]
		: i_present_powerdown;
	assign code = (smb && q.regs[rmrx_pkg::REG_DET][rmrx_pkg::DET_OVR_BIT])
		? q.regs[rmrx_pkg::REG_DET][3:2] : i_receiver_detect_select;
	assign code_auto = code == rmrx_pkg::DET_LIM || code == rmrx_pkg::DET_AUTO;
	assign tdis = smb ? q.regs[rmrx_pkg::REG_TERM_DIS] : 8'h00;

	// ----------------------------------------
	// Per-lane settings
	// ----------------------------------------
	for (genvar g = 0; g < rmrx_pkg::NCH; g++) begin : g_lane
		localparam logic [7:0] EQ_IX = rmrx_pkg::REG_EQ0 + 8'(g);
		localparam logic [7:0] SW_IX = rmrx_pkg::REG_SWING0 + 8'(g);
		logic [3:0] eqp;
		logic [3:0] swp;
		assign eqp = (g < 4) ? i_equalizer_level_pins_a : i_equalizer_level_pins_b;
		assign swp = (g < 4) ? i_side_swing_deemphasis_pins_a
			: i_side_swing_deemphasis_pins_b;
		assign eq_nx[g] = smb ? q.regs[EQ_IX[4:0]] : rmrx_pkg::EQ_TAB[eqp];
		assign sw_nx[g] = smb ? q.regs[SW_IX[4:0]] : {4'h0, swp};
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.scl_p = i_scl;
		d.sda_p = i_sda;
		d.probe = 1'b0;
		// SMBus slave
		if (!slave || stop) begin
			d.sst = rmrx_pkg::SM_IDLE;
			d.sda_oe = 1'b0;
		end else if (start) begin
			d.sst = rmrx_pkg::SM_ADDR;
			d.bcnt = 4'h0;
			d.sda_oe = 1'b0;
		end else if (rise) begin
			if (q.sst inside {rmrx_pkg::SM_ADDR, rmrx_pkg::SM_INDEX, rmrx_pkg::SM_DATA,
				rmrx_pkg::SM_READ}) begin
				d.sh = {q.sh[6:0], i_sda};
				d.bcnt = q.bcnt + 4'h1;
			end
			if (q.sst == rmrx_pkg::SM_RACK && i_sda) begin
				d.sst = rmrx_pkg::SM_IGN;
			end
		end else if (fall) begin
			unique case (q.sst)
				rmrx_pkg::SM_ADDR: begin
					if (q.bcnt == 4'h8) begin
						if (q.sh[7:1] == addr) begin
							d.sda_oe = 1'b1;
							d.rw = q.sh[0];
							d.sst = rmrx_pkg::SM_AACK;
						end else begin
							d.sst = rmrx_pkg::SM_IGN;
						end
					end
				end
				rmrx_pkg::SM_INDEX: begin
					if (q.bcnt == 4'h8) begin
						d.idx = q.sh;
						d.sda_oe = 1'b1;
						d.sst = rmrx_pkg::SM_IACK;
					end
				end
				rmrx_pkg::SM_DATA: begin
					if (q.bcnt == 4'h8) begin
						if (q.idx < rmrx_pkg::REG_NUM) begin
							d.regs[q.idx[4:0]] = q.sh;
						end
						d.sda_oe = 1'b1;
						d.sst = rmrx_pkg::SM_DACK;
					end
				end
				rmrx_pkg::SM_AACK: begin
					d.bcnt = 4'h0;
					if (q.rw) begin
						d.sh = rdata;
						d.sda_oe = !rdata[7];
						d.sst = rmrx_pkg::SM_READ;
					end else begin
						d.sda_oe = 1'b0;
						d.sst = rmrx_pkg::SM_INDEX;
					end
				end
				rmrx_pkg::SM_IACK, rmrx_pkg::SM_DACK: begin
					d.sda_oe = 1'b0;
					d.bcnt = 4'h0;
					d.sst = rmrx_pkg::SM_DATA;
					if (q.sst == rmrx_pkg::SM_DACK) begin
						d.idx = q.idx + 8'h01;
					end
				end
				rmrx_pkg::SM_READ: begin
					if (q.bcnt == 4'h8) begin
						d.sda_oe = 1'b0;
						d.sst = rmrx_pkg::SM_RACK;
					end else begin
						d.sda_oe = !q.sh[7];
					end
				end
				rmrx_pkg::SM_RACK: begin
					d.bcnt = 4'h0;
					d.sh = rdata;
					d.sda_oe = !rdata[7];
					d.sst = rmrx_pkg::SM_READ;
				end
				rmrx_pkg::SM_IDLE, rmrx_pkg::SM_IGN: begin
				end
			endcase
		end
		// Power-down does not touch registers; mode pin low clears them
		if (pinm) begin
			d.regs = '0;
		end
		// Receiver detect
		if (pd) begin
			d.dst = rmrx_pkg::RX_PWDN;
			if (q.pdcnt != 8'hFF) begin
				d.pdcnt = q.pdcnt + 8'h01;
			end
		end else if (q.dst == rmrx_pkg::RX_PWDN) begin
			d.dst = rmrx_pkg::RX_RUN;
			d.pdcnt = 8'h00;
			if (q.pdcnt >= 8'(rmrx_pkg::PULSE_CYC) || sw_ovr) begin
				d.found = '0;
				d.ivl = '0;
				d.lim = '0;
			end
		end else if (!code_auto) begin
			d.ivl = '0;
			d.lim = '0;
		end else if (q.dst == rmrx_pkg::RX_RUN || code == rmrx_pkg::DET_AUTO) begin
			d.found = q.found | (q.probe ? i_rx_found : 8'h00);
			if (q.ivl == rmrx_pkg::CNT_W'(PROBE_CYC - 1)) begin
				d.ivl = '0;
				d.probe = q.found != 8'hFF;
			end else begin
				d.ivl = q.ivl + rmrx_pkg::CNT_W'(1);
			end
			if (code == rmrx_pkg::DET_LIM) begin
				d.lim = q.lim + rmrx_pkg::CNT_W'(1);
				if (q.lim == rmrx_pkg::CNT_W'(LIMIT_CYC - 1)) begin
					d.dst = rmrx_pkg::RX_HALT;
				end
			end
		end
		if (pd) begin
			d.term = '0;
		end else if (code == rmrx_pkg::DET_50) begin
			d.term = ~tdis;
		end else if (code == rmrx_pkg::DET_HIZ) begin
			d.term = '0;
		end else begin
			d.term = d.found & ~tdis;
		end
		d.drv = !pd;
		// Configuration outputs
		d.eq = eq_nx;
		d.swing = sw_nx;
		d.thr = (smb && q.regs[rmrx_pkg::REG_THR][rmrx_pkg::THR_OVR_BIT])
			? q.regs[rmrx_pkg::REG_THR][3:0]
			: {2{rmrx_pkg::THR_MAP[i_idle_threshold_select]}};
		d.rate = (smb && q.regs[rmrx_pkg::REG_RATE][rmrx_pkg::RATE_OVR_BIT])
			? q.regs[rmrx_pkg::REG_RATE][1:0] : i_rate_select;
		d.all_gen = d.rate == rmrx_pkg::LVL_F;
		d.slave = slave;
		d.master = i_config_source_select == rmrx_pkg::LVL_F;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q <= rmrx_pkg::ST_RST;
		end else begin
			q <= d;
		end
	end

	assign o_sda_o = 1'b0;
	assign o_sda_oe = q.sda_oe;
	assign o_term_50 = q.term;
	assign o_drv_en = q.drv;
	assign o_probe = q.probe;
	assign o_eq_code = q.eq;
	assign o_output_swing_deemphasis_level = q.swing;
	assign o_idle_thr = q.thr;
	assign o_rate = q.rate;
	assign o_deemph_all_gen = q.all_gen;
	assign o_slave_mode = q.slave;
	assign o_master_mode = q.master;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	pwdn_off_a: assert property (pd |=> o_term_50 == 8'h00 && !o_drv_en)
		else $error("power-down left inputs terminated or drivers on");
	manual_hiz_a: assert property (!pd && code == rmrx_pkg::DET_HIZ |=> o_term_50 == 8'h00)
		else $error("manual high impedance not held");
	manual_50_a: assert property (pinm && !pd && code == rmrx_pkg::DET_50
		|=> o_term_50 == 8'hFF)
		else $error("manual 50 ohm not held");
	halt_probe_a: assert property (q.dst == rmrx_pkg::RX_HALT && code == rmrx_pkg::DET_LIM
		|=> !o_probe)
		else $error("probe after time limit");
	probe_gap_a: assert property (o_probe |=> !o_probe [*2])
		else $error("probe strobes too close");
	restart_a: assert property (!pd && q.dst == rmrx_pkg::RX_PWDN
		&& q.pdcnt >= 8'(rmrx_pkg::PULSE_CYC) |=> q.found == '0)
		else $error("long power-down pulse did not restart detection");
	sw_pd_a: assert property (sw_ovr && q.regs[rmrx_pkg::REG_DET][rmrx_pkg::PD_VAL_BIT]
		|=> !o_drv_en)
		else $error("software power-down ignored");
	thr_map_a: assert property (pinm && i_idle_threshold_select == rmrx_pkg::LVL_LO
		|=> o_idle_thr == 4'hA)
		else $error("threshold map wrong");
	mode_a: assert property (i_config_source_select == rmrx_pkg::LVL_F
		|=> o_master_mode && !o_slave_mode)
		else $error("float mode pin not master loading");
	reg_clear_a: assert property (pinm |=> q.regs == '0)
		else $error("registers kept in pin mode");
	reg_eq_a: assert property (smb |=> o_eq_code[7:0] == $past(q.regs[16]))
		else $error("equalizer not taken from register");
	addr_miss_a: assert property (fall && slave && !start && !stop && q.sst == rmrx_pkg::SM_ADDR
		&& q.bcnt == 4'h8 && q.sh[7:1] != addr |=> !o_sda_oe)
		else $error("acknowledged wrong address");
	all_gen_a: assert property (pinm && i_rate_select == rmrx_pkg::LVL_F
		|=> o_deemph_all_gen)
		else $error("floating rate not all generations");
	data_ack_a: assert property (fall && slave && q.sst == rmrx_pkg::SM_DATA
		&& q.bcnt == 4'h8 |=> o_sda_oe)
		else $error("data byte not acknowledged");
	found_term_a: assert property (!pd && q.dst != rmrx_pkg::RX_PWDN
		&& code == rmrx_pkg::DET_AUTO && tdis == 8'h00 && o_probe && i_rx_found == 8'hFF
		|=> o_term_50 == 8'hFF)
		else $error("found receivers not terminated");
	rate_ovr_a: assert property (smb && q.regs[rmrx_pkg::REG_RATE][rmrx_pkg::RATE_OVR_BIT]
		|=> o_rate == $past(q.regs[rmrx_pkg::REG_RATE][1:0]))
		else $error("rate override ignored");

	probe_c: cover property (o_probe ##1 o_term_50 != 8'h00);
	write_c: cover property (q.sst == rmrx_pkg::SM_DACK ##[1:40] stop);
	read_c: cover property (q.sst == rmrx_pkg::SM_RACK ##[1:40] stop);
	halt_c: cover property (q.dst == rmrx_pkg::RX_HALT && code == rmrx_pkg::DET_LIM);
	sw_restart_c: cover property (sw_ovr && !pd && q.dst == rmrx_pkg::RX_PWDN);
endmodule : rmrx_ctrl
`default_nettype wire

// file: src/rmrx_pkg.sv
package rmrx_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int PROBE_MS = 12;
	localparam int LIMIT_MS = 600;
	localparam int PULSE_US = 5;
	localparam int PULSE_CYC = (PULSE_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int PROBE_CYC = PROBE_MS * (CLK_HZ / 1000);
	localparam int LIMIT_CYC = LIMIT_MS * (CLK_HZ / 1000);
	localparam int CNT_W = 25;
	localparam int NCH = 8;
	// ----------------------------------------
	// Four-level pin codes and detect selections
	// ----------------------------------------
	localparam logic [1:0] LVL_LO = 2'h0;
	localparam logic [1:0] LVL_R = 2'h1;
	localparam logic [1:0] LVL_F = 2'h2;
	localparam logic [1:0] LVL_HI = 2'h3;
	localparam logic [1:0] DET_HIZ = 2'h0;
	localparam logic [1:0] DET_LIM = 2'h1;
	localparam logic [1:0] DET_AUTO = 2'h2;
	localparam logic [1:0] DET_50 = 2'h3;
	// ----------------------------------------
	// Register indices, bits and reset value
	// ----------------------------------------
	localparam logic [7:0] REG_TERM_DIS = 8'h01;
	localparam logic [7:0] REG_DET = 8'h02;
	localparam logic [7:0] REG_THR = 8'h03;
	localparam logic [7:0] REG_RATE = 8'h04;
	localparam logic [7:0] REG_EQ0 = 8'h10;
	localparam logic [7:0] REG_SWING0 = 8'h18;
	localparam logic [7:0] REG_NUM = 8'h20;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam int PD_OVR_BIT = 7;
	localparam int PD_VAL_BIT = 6;
	localparam int DET_OVR_BIT = 5;
	localparam int THR_OVR_BIT = 7;
	localparam int RATE_OVR_BIT = 7;
	localparam logic [6:0] SLV_BASE = 7'h58;
	// Pin-mode equalizer subset, indexed by the two pin levels
	localparam logic [15:0][7:0] EQ_TAB = {
		8'hFF, 8'hBF, 8'h7F, 8'hAA, 8'h3F, 8'h2F, 8'h1F, 8'h55,
		8'h0F, 8'h0B, 8'h15, 8'h07, 8'h03, 8'h02, 8'h01, 8'h00};
	// Threshold code per pin level: 0, R, F, 1
	localparam logic [3:0][1:0] THR_MAP = {2'h3, 2'h0, 2'h1, 2'h2};
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {SM_IDLE, SM_ADDR, SM_AACK, SM_INDEX, SM_IACK, SM_DATA,
		SM_DACK, SM_READ, SM_RACK, SM_IGN} rmrx_smb_t;
	typedef enum logic [1:0] {RX_RUN, RX_HALT, RX_PWDN} rmrx_det_t;
	typedef struct packed {
		rmrx_smb_t sst;
		logic [3:0] bcnt;
		logic [7:0] sh;
		logic [7:0] idx;
		logic rw;
		logic sda_oe;
		logic scl_p;
		logic sda_p;
		logic [31:0][7:0] regs;
		rmrx_det_t dst;
		logic [CNT_W-1:0] ivl;
		logic [CNT_W-1:0] lim;
		logic [7:0] pdcnt;
		logic [NCH-1:0] found;
		logic probe;
		logic [NCH-1:0] term;
		logic drv;
		logic [NCH-1:0][7:0] eq;
		logic [NCH-1:0][7:0] swing;
		logic [3:0] thr;
		logic [1:0] rate;
		logic all_gen;
		logic slave;
		logic master;
	} rmrx_st_t;
	// Reset state; bus lines idle high so no false edge follows reset
	localparam rmrx_st_t ST_RST = '{sst: SM_IDLE, dst: RX_RUN, scl_p: 1'b1, sda_p: 1'b1,
		default: '0};
endpackage : rmrx_pkg

// file: sim/rmrx_partner.sv
`timescale 1ns/1ps
`default_nettype none
module rmrx_partner (
	input wire logic i_sys_clk,   // System clock
	input wire logic i_probe,     // Probe strobe
	input wire logic i_sda_o,     // Device data out
	input wire logic i_sda_oe,    // Device pulls data low
	output logic o_scl,           // Bus clock
	output logic o_sda,           // Bus data level
	output logic [7:0] o_rx_found // Probe answer
);
	logic [7:0] present = 8'h00;
	logic scl_q = 1'b1;
	logic pull_q = 1'b0;
	// ----------------------------------------
	// Wire levels
	// ----------------------------------------
	assign o_scl = scl_q;
	assign o_sda = !(pull_q || (i_sda_oe && !i_sda_o));
	// Outside the probe cycle the answer is deliberately wrong
	assign o_rx_found = i_probe ? present : ~present;
	// ----------------------------------------
	// Host bit engine, four clocks per phase
	// ----------------------------------------
	task automatic step(input logic c, input logic p);
		scl_q = c;
		pull_q = p;
		repeat (4) @(negedge i_sys_clk);
	endtask : step
	task automatic wbit(input logic b);
		step(1'b0, !b);
		step(1'b1, !b);
		step(1'b0, !b);
	endtask : wbit
	task automatic rbit(output logic b);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		b = o_sda;
		step(1'b0, 1'b0);
	endtask : rbit
	task automatic wbyte(input logic [7:0] v, output logic a);
		for (int i = 7; i >= 0; i--) begin
			wbit(v[i]);
		end
		rbit(a);
	endtask : wbyte
	task automatic smb_write(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
		output logic [2:0] ak);
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
		wbyte({a, 1'b0}, ak[2]);
		wbyte(idx, ak[1]);
		wbyte(d, ak[0]);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask : smb_write
	task automatic smb_read(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d,
		output logic [2:0] ak);
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
		wbyte({a, 1'b0}, ak[2]);
		wbyte(idx, ak[1]);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
		wbyte({a, 1'b1}, ak[0]);
		for (int i = 7; i >= 0; i--) begin
			rbit(d[i]);
		end
		wbit(1'b1);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask : smb_read
endmodule : rmrx_partner
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin exp_q.push_back(rmrx_note_t'{nm, 64'(e)}); got_q.push_back(64'(g)); end
module tb_top;
	typedef struct {string nm; logic [63:0] v;} rmrx_note_t;
	localparam int PRB = 20;
	localparam int LIM = 200;
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [1:0] i_config_source_select = 2'h0;
	logic i_present_powerdown = 1'b0;
	logic [1:0] i_receiver_detect_select = 2'h2;
	logic [1:0] i_idle_threshold_select = 2'h2;
	logic [1:0] i_rate_select = 2'h0;
	logic [3:0] eqa = 4'h0, eqb = 4'h0, swa = 4'h0, swb = 4'h0;
	wire logic scl, sda, sda_o, sda_oe, probe, drv, all_gen, slave, master;
	wire logic [7:0] rx_found, term;
	wire logic [63:0] eq_code, swing;
	wire logic [3:0] thr;
	wire logic [1:0] rate;
	rmrx_note_t exp_q[$];
	logic [63:0] got_q[$];
	rmrx_note_t note;
	logic [63:0] seen;
	int num_errors = 0, num_checks = 0, cyc = 0, n_probe = 0, last_p = 0, gap = 0, n0, ln;
	logic [7:0] eq_tab [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0B, 8'h0F,
		8'h55, 8'h1F, 8'h2F, 8'h3F, 8'hAA, 8'h7F, 8'hBF, 8'hFF};
	logic [1:0] thr_exp [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
	logic [3:0] ad;
	logic [6:0] sa;
	logic [7:0] v;
	logic [2:0] ak;
	always #12.5 i_sys_clk = ~i_sys_clk;
	rmrx_ctrl #(.PROBE_CYC(PRB), .LIMIT_CYC(LIM)) i_rmrx_ctrl (.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn), .i_config_source_select(i_config_source_select),
		.i_present_powerdown(i_present_powerdown), .i_receiver_detect_select(i_receiver_detect_select),
		.i_idle_threshold_select(i_idle_threshold_select), .i_rate_select(i_rate_select),
		.i_equalizer_level_pins_a(eqa), .i_equalizer_level_pins_b(eqb),
		.i_side_swing_deemphasis_pins_a(swa), .i_side_swing_deemphasis_pins_b(swb),
		.i_rx_found(rx_found), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
		.o_term_50(term), .o_drv_en(drv), .o_probe(probe), .o_eq_code(eq_code),
		.o_output_swing_deemphasis_level(swing), .o_idle_thr(thr), .o_rate(rate),
		.o_deemph_all_gen(all_gen), .o_slave_mode(slave), .o_master_mode(master));
	rmrx_partner i_rmrx_partner (.i_sys_clk(i_sys_clk), .i_probe(probe), .i_sda_o(sda_o),
		.i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda), .o_rx_found(rx_found));
	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge i_sys_clk) begin
		cyc = cyc + 1;
		if (probe === 1'b1) begin
			gap = cyc - last_p;
			last_p = cyc;
			n_probe = n_probe + 1;
		end
		while (got_q.size() > 0) begin
			note = exp_q.pop_front();
			seen = got_q.pop_front();
			num_checks++;
			if (seen !== note.v) begin
				num_errors++;
				$display("[ERR] %s expected %0h seen %0h", note.nm, note.v, seen);
			end
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : tick
	task automatic pd_pulse(input int n);
		i_present_powerdown = 1'b1;
		tick(n);
		i_present_powerdown = 1'b0;
		tick(3);
	endtask : pd_pulse
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [2:0] a;
		i_rmrx_partner.smb_write(sa, idx, d, a);
		`CHECK("wr_ack", 3'h0, a)
		tick(2);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		logic [2:0] a;
		logic [7:0] d;
		i_rmrx_partner.smb_read(sa, idx, d, a);
		`CHECK("rd_ack", 3'h0, a)
		`CHECK("rd_data", e, d)
		tick(2);
	endtask : rd
	task automatic tally_and_finish;
		tick(2);
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (40000) @(posedge i_sys_clk);
		num_errors++;
		$display("[ERR] watchdog expired");
		tally_and_finish();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(32'h203F16E4));
		tick(16);
		`CHECK("rst_term", 8'h00, term)
		i_rstn = 1'b1;
		tick(3);
		for (int i = 0; i < 4; i++) begin
			i_idle_threshold_select = 2'(i);
			tick(2);
			`CHECK("thr", {thr_exp[i], thr_exp[i]}, thr)
		end
		i_rate_select = rmrx_pkg::LVL_F;
		tick(2);
		`CHECK("all_gen", 1'b1, all_gen)
		`CHECK("rate", rmrx_pkg::LVL_F, rate)
		for (int k = 0; k < 3; k++) begin
			{eqa, eqb, swa, swb} = 16'($urandom);
			tick(2);
			for (int l = 0; l < 8; l++) begin
				`CHECK("eq", eq_tab[l < 4 ? eqa : eqb], eq_code[l*8 +: 8])
				`CHECK("swing", {4'h0, l < 4 ? swa : swb}, swing[l*8 +: 8])
			end
		end
		`CHECK("drv", 1'b1, drv)
		tick(50);
		`CHECK("term_none", 8'h00, term)
		`CHECK("gap", PRB, gap)
		i_rmrx_partner.present = 8'hA5;
		tick(2 * PRB + 5);
		`CHECK("term_found", 8'hA5, term)
		i_present_powerdown = 1'b1;
		tick(1);
		n0 = n_probe;
		tick(59);
		`CHECK("pd_term", 8'h00, term)
		`CHECK("pd_drv", 1'b0, drv)
		`CHECK("pd_probes", 0, n_probe - n0)
		i_present_powerdown = 1'b0;
		tick(3);
		`CHECK("short_pulse", 8'hA5, term)
		i_rmrx_partner.present = 8'h00;
		pd_pulse(210);
		`CHECK("restart", 8'h00, term)
		i_receiver_detect_select = 2'h3;
		tick(2);
		`CHECK("term_50", 8'hFF, term)
		i_receiver_detect_select = 2'h0;
		n0 = n_probe;
		tick(50);
		`CHECK("term_hiz", 8'h00, term)
		`CHECK("man_probes", 0, n_probe - n0)
		i_receiver_detect_select = 2'h1;
		pd_pulse(210);
		n0 = n_probe;
		tick(LIM + 100);
		`CHECK("lim_cnt", 1'b1, (n_probe - n0 >= 9 && n_probe - n0 <= 11))
		`CHECK("lim_stop", 1'b1, (cyc - last_p > 2 * PRB))
		i_rmrx_partner.present = 8'hFF;
		tick(2 * PRB);
		`CHECK("lim_term", 8'h00, term)
		i_receiver_detect_select = 2'h2;
		ad = 4'($urandom);
		sa = 7'h58 + 7'(ad);
		eqa = {2'h1, ad[0] ? 2'h3 : 2'h0};
		eqb = {2'h2, ad[1] ? 2'h3 : 2'h0};
		swa = {2'h0, ad[2] ? 2'h3 : 2'h0};
		swb = {2'h3, ad[3] ? 2'h3 : 2'h0};
		i_idle_threshold_select = 2'h0;
		i_config_source_select = 2'h3;
		tick(3);
		`CHECK("slave", 2'h2, {slave, master})
		`CHECK("reg_eq", 64'h0, eq_code)
		`CHECK("thr_pin", 4'hA, thr)
		ln = $urandom % 8;
		v = 8'($urandom);
		wr(8'h10 + 8'(ln), v);
		`CHECK("lane_eq", v, eq_code[ln*8 +: 8])
		rd(8'h10 + 8'(ln), v);
		i_rmrx_partner.smb_write(sa ^ 7'h01, 8'h10 + 8'(ln), ~v, ak);
		`CHECK("nack", 1'b1, ak[2])
		rd(8'h10 + 8'(ln), v);
		wr(8'h20, 8'h5A);
		rd(8'h20, 8'h00);
		wr(8'h03, 8'h85);
		`CHECK("thr_ovr", 4'h5, thr)
		wr(8'h04, 8'h81);
		`CHECK("rate_ovr", 2'h1, rate)
		`CHECK("gen_ovr", 1'b0, all_gen)
		pd_pulse(20);
		rd(8'h10 + 8'(ln), v);
		`CHECK("term_pre", 8'hFF, term)
		i_rmrx_partner.present = 8'h00;
		wr(8'h02, 8'h80);
		wr(8'h02, 8'hC0);
		wr(8'h02, 8'h80);
		`CHECK("sw_restart", 8'h00, term)
		wr(8'h02, 8'h2C);
		`CHECK("det_ovr", 8'hFF, term)
		wr(8'h01, 8'h0F);
		`CHECK("term_dis", 8'hF0, term)
		i_config_source_select = 2'h0;
		tick(3);
		i_config_source_select = 2'h3;
		tick(3);
		`CHECK("thr_back", 4'hA, thr)
		rd(8'h10 + 8'(ln), 8'h00);
		i_config_source_select = 2'h2;
		tick(2);
		`CHECK("master", 2'h1, {slave, master})
		i_config_source_select = 2'h0;
		tick(2);
		`CHECK("pin_mode", 2'h0, {slave, master})
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
